// ---- src/cbk_pkg.sv ----
// Package: register map, field layout and reset values of the configuration bank
package cbk_pkg;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [7:0] ADDR_UPPER_OUTPUT_GATE   = 8'h02;
  localparam logic [7:0] ADDR_SPARE_BYTE_THREE    = 8'h03;
  localparam logic [7:0] ADDR_SPARE_BYTE_FOUR     = 8'h04;
  localparam logic [7:0] ADDR_MAKER_AND_REVISION  = 8'h05;
  localparam logic [7:0] ADDR_PART_IDENTIFICATION = 8'h06;
  localparam logic [7:0] ADDR_BLOCK_READ_LENGTH   = 8'h07;
  localparam logic [7:0] ADDR_CHAN_A_ADVANCE      = 8'h08;
  localparam logic [7:0] ADDR_CHAN_B_ADVANCE      = 8'h09;
  // ----------------------------------------
  // Field widths and reset values
  // ----------------------------------------
  localparam int         GATE_W           = 4;
  localparam int         LEN_W            = 5;
  localparam int         ADV_W            = 3;
  localparam int         PHASE_W          = 5;
  localparam logic [3:0] GATE_RESET       = 4'hf;
  localparam logic [4:0] LEN_RESET        = 5'h08;
  localparam logic [2:0] ADV_RESET        = 3'h0;
  localparam logic [4:0] VCO_PER_CYCLE    = 5'h18;
  // Identification codes: values arbitrary
  localparam logic [3:0] REVISION_CODE    = 4'h3;
  localparam logic [3:0] MAKER_CODE       = 4'h5;
  localparam logic [7:0] PART_CODE        = 8'h5a;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } cbk_req_s;
endpackage

// ---- src/cbk_phase_accum.sv ----
// Modulo accumulator of phase advance for one input channel
module cbk_phase_accum #(
  parameter int              ADV_W   = 3,
  parameter int              PHASE_W = 5,
  parameter logic [PHASE_W-1:0] MODULUS = 5'h18
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               add,
  input  wire logic [ADV_W-1:0]   amount,
  output logic      [PHASE_W-1:0] phase
);
  logic [PHASE_W:0] sum;
  assign sum = {1'b0, phase} + {{(PHASE_W+1-ADV_W){1'b0}}, amount};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= '0;
    end else if (add) begin
      phase <= (sum >= {1'b0, MODULUS}) ? PHASE_W'(sum - {1'b0, MODULUS})
                                        : sum[PHASE_W-1:0];
    end
  end
endmodule

// ---- src/cbk_config_bank.sv ----
// Configuration bank: output gates, identification, read length, phase advance
module cbk_config_bank (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire cbk_pkg::cbk_req_s req,
  input  wire logic              sel_chan_a,
  input  wire logic              oe_pin_pair8,
  input  wire logic              oe_pin_pair9,
  input  wire logic              oe_pin_pair10,
  input  wire logic              oe_pin_pair11,
  output logic [7:0]             rdata,
  output logic [3:0]             pair_enable,
  output logic [4:0]             block_read_length,
  output logic [4:0]             active_advance,
  output logic [4:0]             phase_a,
  output logic [4:0]             phase_b
);
  // ----------------------------------------
  // Writable state
  // ----------------------------------------
  logic [3:0] output_gate;
  logic [2:0] chan_a_advance;
  logic [2:0] chan_b_advance;
  logic [4:0] next_active;
  logic [3:0] next_enable;
  logic [7:0] next_rdata;

  wire wr_gate = req.wr && (req.index == cbk_pkg::ADDR_UPPER_OUTPUT_GATE);
  wire wr_len  = req.wr && (req.index == cbk_pkg::ADDR_BLOCK_READ_LENGTH);
  wire wr_a    = req.wr && (req.index == cbk_pkg::ADDR_CHAN_A_ADVANCE);
  wire wr_b    = req.wr && (req.index == cbk_pkg::ADDR_CHAN_B_ADVANCE);
  wire [4:0] acc_a;
  wire [4:0] acc_b;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_gate       <= cbk_pkg::GATE_RESET;
      block_read_length <= cbk_pkg::LEN_RESET;
      chan_a_advance    <= cbk_pkg::ADV_RESET;
      chan_b_advance    <= cbk_pkg::ADV_RESET;
    end else begin
      if (wr_gate) output_gate <= req.wdata[3:0];
      if (wr_len)  block_read_length <= req.wdata[4:0];
      if (wr_a)    chan_a_advance <= req.wdata[2:0];
      if (wr_b)    chan_b_advance <= req.wdata[2:0];
    end
  end

  // ----------------------------------------
  // Phase accumulators
  // ----------------------------------------
  // one increment per write, modulo
  cbk_phase_accum #(
    .ADV_W   (cbk_pkg::ADV_W),
    .PHASE_W (cbk_pkg::PHASE_W),
    .MODULUS (cbk_pkg::VCO_PER_CYCLE)
  ) u_acc_a (
    .clk    (clk),
    .rst    (rst),
    .add    (wr_a),
    .amount (req.wdata[2:0]),
    .phase  (acc_a)
  );
  cbk_phase_accum #(
    .ADV_W   (cbk_pkg::ADV_W),
    .PHASE_W (cbk_pkg::PHASE_W),
    .MODULUS (cbk_pkg::VCO_PER_CYCLE)
  ) u_acc_b (
    .clk    (clk),
    .rst    (rst),
    .add    (wr_b),
    .amount (req.wdata[2:0]),
    .phase  (acc_b)
  );

  // selected channel drives the output phase
  assign next_active = sel_chan_a ? acc_a : acc_b;
  // zero forces low/low, one defers to pin
  assign next_enable = output_gate &
                       {oe_pin_pair11, oe_pin_pair10, oe_pin_pair9, oe_pin_pair8};

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // fixed codes, reserved read zero
  always_comb begin
    next_rdata = 8'h00;
    case (req.index)
      cbk_pkg::ADDR_UPPER_OUTPUT_GATE:   next_rdata = {4'h0, output_gate};
      cbk_pkg::ADDR_MAKER_AND_REVISION:  next_rdata = {cbk_pkg::REVISION_CODE,
                                                       cbk_pkg::MAKER_CODE};
      cbk_pkg::ADDR_PART_IDENTIFICATION: next_rdata = cbk_pkg::PART_CODE;
      cbk_pkg::ADDR_BLOCK_READ_LENGTH:   next_rdata = {3'h0, block_read_length};
      cbk_pkg::ADDR_CHAN_A_ADVANCE:      next_rdata = {5'h00, chan_a_advance};
      cbk_pkg::ADDR_CHAN_B_ADVANCE:      next_rdata = {5'h00, chan_b_advance};
      default:                           next_rdata = 8'h00;
    endcase
  end

  // byte data registered for the serialiser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata          <= 8'h00;
      pair_enable    <= 4'h0;
      active_advance <= 5'h00;
      phase_a        <= 5'h00;
      phase_b        <= 5'h00;
    end else begin
      if (req.rd) rdata <= next_rdata;
      pair_enable    <= next_enable;
      active_advance <= next_active;
      phase_a        <= acc_a;
      phase_b        <= acc_b;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_gate_reg;
    wr_gate ##1 1 |=> (pair_enable ==
      ($past(req.wdata[3:0], 2) & $past({oe_pin_pair11, oe_pin_pair10,
                                         oe_pin_pair9, oe_pin_pair8})));
  endproperty
  a_gate_reg: assert property (p_gate_reg) else $error("gate mismatch");

  property p_id_read;
    req.rd && req.index == cbk_pkg::ADDR_MAKER_AND_REVISION |=>
      rdata == {cbk_pkg::REVISION_CODE, cbk_pkg::MAKER_CODE};
  endproperty
  a_id_read: assert property (p_id_read) else $error("id byte wrong");

  property p_len_write;
    wr_len |=> block_read_length == $past(req.wdata[4:0]);
  endproperty
  a_len_write: assert property (p_len_write) else $error("length lost");

  property p_part_read;
    req.rd && req.index == cbk_pkg::ADDR_PART_IDENTIFICATION |=> rdata == cbk_pkg::PART_CODE;
  endproperty
  a_part_read: assert property (p_part_read) else $error("part id wrong");

  property p_sel_a;
    sel_chan_a |=> active_advance == $past(acc_a);
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("A not applied");

  property p_sel_b;
    !sel_chan_a |=> active_advance == $past(acc_b);
  endproperty
  a_sel_b: assert property (p_sel_b) else $error("B not applied");

  property p_accum_a;
    wr_a && acc_a + 5'(req.wdata[2:0]) < cbk_pkg::VCO_PER_CYCLE |=>
      acc_a == $past(acc_a) + 5'($past(req.wdata[2:0]));
  endproperty
  a_accum_a: assert property (p_accum_a) else $error("A add wrong");

  property p_accum_b;
    wr_b && acc_b + 5'(req.wdata[2:0]) < cbk_pkg::VCO_PER_CYCLE |=>
      acc_b == $past(acc_b) + 5'($past(req.wdata[2:0]));
  endproperty
  a_accum_b: assert property (p_accum_b) else $error("B add wrong");

  property p_hold_a;
    !wr_a |=> acc_a == $past(acc_a);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("A drifted");

  property p_hold_b;
    !wr_b |=> acc_b == $past(acc_b);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("B drifted");

  property p_wrap;
    acc_a < cbk_pkg::VCO_PER_CYCLE && acc_b < cbk_pkg::VCO_PER_CYCLE;
  endproperty
  a_wrap: assert property (p_wrap) else $error("phase out of range");

  property p_wrap_a;
    wr_a && acc_a + 5'(req.wdata[2:0]) >= cbk_pkg::VCO_PER_CYCLE |=>
      acc_a == $past(acc_a) + 5'($past(req.wdata[2:0])) - cbk_pkg::VCO_PER_CYCLE;
  endproperty
  a_wrap_a: assert property (p_wrap_a) else $error("A wrap wrong");

  property p_wrap_b;
    wr_b && acc_b + 5'(req.wdata[2:0]) >= cbk_pkg::VCO_PER_CYCLE |=>
      acc_b == $past(acc_b) + 5'($past(req.wdata[2:0])) - cbk_pkg::VCO_PER_CYCLE;
  endproperty
  a_wrap_b: assert property (p_wrap_b) else $error("B wrap wrong");

  property p_rsvd;
    req.rd && req.index == cbk_pkg::ADDR_CHAN_B_ADVANCE |=> rdata[7:3] == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

  property p_gate_rsvd;
    req.rd && req.index == cbk_pkg::ADDR_UPPER_OUTPUT_GATE |=> rdata[7:4] == 4'h0;
  endproperty
  a_gate_rsvd: assert property (p_gate_rsvd) else $error("gate reserved set");

  property p_rdata_hold;
    !req.rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read byte moved");

  c_wrap_a:   cover property (wr_a ##1 acc_a < $past(acc_a));
  c_len_w:    cover property (wr_len);
  c_sel_sw:   cover property (sel_chan_a ##1 !sel_chan_a);
  c_gate_off: cover property (wr_gate && req.wdata[3:0] == 4'h0);
endmodule

// ---- verification/cbk_host_model.sv ----
// Host controller model: indexed byte writes and reads into the bank
module cbk_host_model (
  input  wire logic         clk,
  input  wire logic [7:0]   rdata,
  output cbk_pkg::cbk_req_s req
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] blk [32];

  initial req = '0;

  // One strobe per byte; bus lines show inverted junk once released
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    #1 req = '{wr: w, rd: !w, index: i, wdata: d};
    @(posedge clk);
    #1 req = '{wr: 1'b0, rd: 1'b0, index: ~i, wdata: ~d};
    q = rdata;
  endtask

  // bytes taken in turn, last ends transfer
  task automatic block_read(input logic [7:0] start, input int n);
    for (int j = 0; j < n; j++) begin
      xfer(1'b0, start + 8'(j), 8'h00, blk[j]);
    end
  endtask
endmodule

// ---- verification/cbk_config_bank_test.sv ----
// Self-checking bench of the configuration bank
module cbk_config_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              sel_chan_a = 1'b1;
  logic [3:0]        pins = 4'hf;
  logic [7:0]        rdata, q;
  logic [4:0]        blen, act, pha, phb;
  logic [3:0]        pen;
  cbk_pkg::cbk_req_s req;
  int                num_errors = 0;
  int                cmp_count = 0;
  logic [31:0]       seed = 32'h6e96da43;
  logic [31:0]       r;
  logic [3:0]        gate = cbk_pkg::GATE_RESET;
  logic [4:0]        len = cbk_pkg::LEN_RESET, pa = 5'h00, pb = 5'h00;
  logic [2:0]        ra = 3'h0, rb = 3'h0;
  logic [15:0]       dir [15] = '{16'h0801, 16'h0801, 16'h0802, 16'h0807, 16'h0807,
                                  16'h0807, 16'h09fe, 16'h0906, 16'h0906, 16'h0906,
                                  16'h0906, 16'h05ff, 16'h06ff, 16'h07ff, 16'h02f0};

  cbk_config_bank dut (.clk(clk), .rst(rst), .req(req), .sel_chan_a(sel_chan_a),
    .oe_pin_pair8(pins[0]), .oe_pin_pair9(pins[1]), .oe_pin_pair10(pins[2]),
    .oe_pin_pair11(pins[3]), .rdata(rdata), .pair_enable(pen),
    .block_read_length(blen), .active_advance(act), .phase_a(pha), .phase_b(phb));
  cbk_host_model host (.clk(clk), .rdata(rdata), .req(req));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Unmapped and reserved places read zero
  function automatic logic [7:0] exp_reg(input logic [7:0] i);
    case (i)
      8'h02: return {4'h0, gate};
      8'h05: return {cbk_pkg::REVISION_CODE, cbk_pkg::MAKER_CODE};
      8'h06: return cbk_pkg::PART_CODE;
      8'h07: return {3'h0, len};
      8'h08: return {5'h0, ra};
      8'h09: return {5'h0, rb};
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic do_write(input logic [7:0] i, input logic [7:0] d);
    r = xs();
    pins = r[3:0];
    sel_chan_a = r[4];
    host.xfer(1'b1, i, d, q);
    case (i)
      8'h02: gate = d[3:0];
      8'h07: len = d[4:0];
      8'h08: begin
        ra = d[2:0];
        pa = 5'((pa + d[2:0]) % 24);
      end
      8'h09: begin
        rb = d[2:0];
        pb = 5'((pb + d[2:0]) % 24);
      end
      default: ;
    endcase
    // Phase outputs land two cycles after the write
    repeat (2) @(posedge clk);
    #1 chk("pair_enable", {4'h0, gate & pins}, {4'h0, pen});
    chk("read_length", {3'h0, len}, {3'h0, blen});
    chk("phase_a", {3'h0, pa}, {3'h0, pha});
    chk("phase_b", {3'h0, pb}, {3'h0, phb});
    chk("active", {3'h0, sel_chan_a ? pa : pb}, {3'h0, act});
    host.xfer(1'b0, i, 8'h00, q);
    chk("readback", exp_reg(i), q);
  endtask

  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end

  // Run needs well under a thousand cycles
  initial begin
    #500000;
    num_errors++;
    finish_test();
  end

  // Reset for n cycles, model back to defaults, every byte read back
  task automatic reset_and_scan(input int n);
    rst = 1'b1;
    repeat (n) @(posedge clk);
    #1 rst = 1'b0;
    gate = cbk_pkg::GATE_RESET;
    len  = cbk_pkg::LEN_RESET;
    pa   = 5'h00;
    pb   = 5'h00;
    ra   = 3'h0;
    rb   = 3'h0;
    for (int i = 2; i < 10; i++) begin
      host.xfer(1'b0, 8'(i), 8'h00, q);
      chk("reset_value", exp_reg(8'(i)), q);
    end
  endtask

  initial begin
    reset_and_scan(4);
    foreach (dir[k]) begin
      do_write(dir[k][15:8], dir[k][7:0]);
    end
    // Mid-run reset must clear accumulated phase too
    reset_and_scan(2);
    repeat (60) begin
      r = xs();
      do_write({4'h0, r[11:8]}, r[7:0]);
    end
    // Count first, then bytes 0 up to the count
    host.block_read(8'h00, int'(len) + 1);
    chk("block_count", {3'h0, len}, {3'h0, blen});
    for (int j = 0; j <= int'(len); j++) begin
      chk("block_byte", exp_reg(8'(j)), host.blk[j]);
    end
    finish_test();
  end
endmodule
